// file: atx_transmitter.sv
// Purpose: serial audio input port and bi-phase mark line transmitter
// Assumes: pclk is the master clock, 256 clocks per transmitted frame
// Notes: all pins are sampled on pclk
//
// Overview of operation
// - software picks port role, rate, format, polarities
// - master role drives word and bit clocks
// - word clock synchronous; bit clock may stop
// - short word clock phases accepted if enough bits
// - format bits select left, i2s or right justified
// - i2s word length follows bit clock count
// - samples and control bits bi-phase mark coded
// - transmit timing comes from the master clock
// - slip flag set on each dropped/repeated sample
// - status and user bits from internal storage
// - user bits optionally taken from pin
// - block boundary pin is input or output
// - boundary held high over three clocks restarts block
// - slave with boundary output aligns to word clock
// - line outputs grounded in reset, stopped or off
// - mute replaces audio with silence from the next subframe load
// - line outputs are complementary while running and not switched off
// - bit clock edge and word polarity selectable
//
// Chosen here: the register offsets and the APB slave port.
`include "atx_defines.svh"
`default_nettype none

module atx_transmitter (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        input_word_clock_in,
   output logic             input_word_clock_out,
   output logic             input_word_clock_oe,
   input  wire logic        input_bit_clock_in,
   output logic             input_bit_clock_out,
   output logic             input_bit_clock_oe,
   input  wire logic        serial_audio_in,
   input  wire logic        user_data_in,
   input  wire logic        tx_block_boundary_in,
   output logic             tx_block_boundary_out,
   output logic             tx_block_boundary_oe,
   output logic             tx_slip_flag,
   output logic             line_out_pos,
   output logic             line_out_neg
);
   import atx_pkg::*;

   atx_st_t r_reg;
   atx_st_t r_next;

   logic          ms;
   logic          jr;
   logic          mute;
   logic          on_c;
   logic          bedge;
   logic          wl;
   logic          chg;
   logic          pair_done;
   logic          cons;
   logic          cons_a;
   logic          slipev;
   logic          bbtrig;
   logic          align_ev;
   logic          frc;
   logic          acc;
   logic          wr;
   logic [4:0]    idx;
   logic [4:0]    rb;
   logic [23:0]   word;
   logic [191:0]  csf;
   logic [191:0]  usf;

   assign ms   = r_reg.ctrl[`ATX_B_MS];
   assign jr   = r_reg.ctrl[`ATX_B_JR];
   assign mute = r_reg.ctrl[`ATX_B_MUTE];
   assign csf  = r_reg.cs;
   assign usf  = r_reg.us;
   assign idx  = paddr[6:2];
   assign acc  = psel & penable & r_reg.rdy;
   assign wr   = acc & pwrite;

   // resolution code 00 24, 01 20, 10 16, 11 18 bits
   assign rb = (r_reg.ctrl[3:2] == 2'h1) ? 5'd20 :
               (r_reg.ctrl[3:2] == 2'h2) ? 5'd16 :
               (r_reg.ctrl[3:2] == 2'h3) ? 5'd18 : 5'd24;

   // receiver sees its own clocks in master role
   assign bedge = ((ms ? r_reg.bck : r_reg.bs1) ^ r_reg.ctrl[`ATX_B_BPOL]) & ~r_reg.bpa;
   assign wl    = (ms ? r_reg.wck : r_reg.ws1) ^ r_reg.ctrl[`ATX_B_WPOL];
   assign chg   = bedge & (wl != r_reg.lastwc);
   assign pair_done = chg & ~r_reg.lastwc;

   // right justified keeps the last bits, the others the first ones
   assign word = jr ? (r_reg.sh << (5'd24 - rb)) :
                 (r_reg.n >= 8'd24) ? r_reg.sh :
                 (r_reg.sh << (5'd24 - r_reg.n[4:0]));

   assign cons   = r_reg.fcnt[6:0] == `ATX_LOAD_SLOT;
   assign cons_a = cons & ~r_reg.fcnt[7];
   // no pair since last frame repeats, a second pair drops
   assign slipev = (cons_a & ~r_reg.pend) | (pair_done & r_reg.pend & ~cons_a);

   assign bbtrig   = ~r_reg.ctrl[`ATX_B_BBOUT] & tx_block_boundary_in &
                     (r_reg.bbcnt == `ATX_BB_MIN_HI) & ~r_reg.bbd;
   assign align_ev = ~ms & r_reg.ctrl[`ATX_B_BBOUT] & wl & ~r_reg.wsl;
   assign frc      = bbtrig | align_ev;
   assign on_c     = r_reg.ctrl[`ATX_B_RUN] & ~r_reg.ctrl[`ATX_B_TXOFF];

   function automatic logic [27:0] mkword(input logic [23:0] a,
                                          input logic        c,
                                          input logic        u,
                                          input logic        v,
                                          input logic        m);
      logic [26:0] x;
      x = {c, u, v, (m ? 24'h000000 : a)};
      return {^x, x};
   endfunction

   function automatic logic [31:0] rd_word(input atx_st_t s, input logic [4:0] i);
      logic [31:0] d;
      d = 32'h00000000;
      if (i == `ATX_IDX_CTRL)
         d = {18'h00000, s.ctrl};
      else if (i == `ATX_IDX_STAT)
         d = {31'h00000000, s.slip};
      else if (i >= `ATX_IDX_CS && i < `ATX_IDX_CS + 5'd6)
         d = s.cs[3'(i - `ATX_IDX_CS)];
      else if (i >= `ATX_IDX_US && i < `ATX_IDX_US + 5'd6)
         d = s.us[3'(i - `ATX_IDX_US)];
      return d;
   endfunction

   function automatic logic hit(input logic [11:0] a);
      logic [4:0] i;
      i = a[6:2];
      hit = (a[11:7] == 5'h00) && (a[1:0] == 2'h0) &&
            (i == `ATX_IDX_CTRL || i == `ATX_IDX_STAT ||
             (i >= `ATX_IDX_CS && i < `ATX_IDX_CS + 5'd6) ||
             (i >= `ATX_IDX_US && i < `ATX_IDX_US + 5'd6));
   endfunction

   always_comb begin
      logic [5:0]  hs;
      logic [7:0]  pat;
      logic        base;
      logic [23:0] aud;
      r_next = r_reg;
      hs     = r_reg.fcnt[6:1];
      pat    = `ATX_PRE_M;
      base   = r_reg.lvl;
      aud    = r_reg.hr;

      // apb slave, one wait state
      r_next.rdy = psel & penable & ~r_reg.rdy;
      // error only stands alongside pready so the port comes straight from a flop
      r_next.err = 1'b0;
      if (psel & penable & ~r_reg.rdy) begin
         r_next.rdata = rd_word(r_reg, idx);
         r_next.err   = ~hit(paddr);
      end
      if (wr && hit(paddr)) begin
         if (idx == `ATX_IDX_CTRL)
            r_next.ctrl = pwdata[13:0];
         if (idx >= `ATX_IDX_CS && idx < `ATX_IDX_CS + 5'd6)
            r_next.cs[3'(idx - `ATX_IDX_CS)] = pwdata;
         if (idx >= `ATX_IDX_US && idx < `ATX_IDX_US + 5'd6)
            r_next.us[3'(idx - `ATX_IDX_US)] = pwdata;
      end
      // write one clears, a new slip in the same cycle wins
      r_next.slip = (r_reg.slip & ~(wr && idx == `ATX_IDX_STAT && pwdata[0])) | slipev;

      // pin sampling; bit clock may stop, only edges count
      r_next.bs1 = input_bit_clock_in;
      r_next.ws1 = input_word_clock_in;
      r_next.sd1 = serial_audio_in;
      r_next.bpa = (ms ? r_reg.bck : r_reg.bs1) ^ r_reg.ctrl[`ATX_B_BPOL];
      r_next.wsl = wl;

      // serial receiver
      if (chg) begin
         if (r_reg.lastwc)
            r_next.lw = word;
         else begin
            r_next.pl   = r_reg.lw;
            r_next.pr   = word;
            r_next.pend = 1'b1;
         end
         r_next.lastwc = wl;
         r_next.n      = 8'd0;
         r_next.sh     = 24'h000000;
         if (!r_reg.ctrl[`ATX_B_DLY]) begin
            r_next.sh = {23'h000000, r_reg.sd1};
            r_next.n  = 8'd1;
         end
      end else if (bedge) begin
         // a short phase simply ends the word early
         if (jr || r_reg.n < 8'd24)
            r_next.sh = {r_reg.sh[22:0], r_reg.sd1};
         if (r_reg.n != `ATX_MAX_BITS)
            r_next.n = r_reg.n + 8'd1;
      end

      // master clocks from the frame counter
      r_next.bck = (r_reg.ctrl[`ATX_B_RATE] ? r_reg.fcnt[0] : r_reg.fcnt[1]) ^
                   r_reg.ctrl[`ATX_B_BPOL];
      r_next.wck = ~r_reg.fcnt[7] ^ r_reg.ctrl[`ATX_B_WPOL];

      // frame timing runs on pclk; boundary input and word clock alignment restart it
      r_next.fcnt = r_reg.fcnt + 8'd1;
      if (r_reg.fcnt == 8'hff || align_ev)
         r_next.fr = (r_reg.fr == `ATX_BLOCK_LAST) ? 8'd0 : r_reg.fr + 8'd1;
      if (frc)
         r_next.fcnt = 8'h00;
      if (bbtrig)
         r_next.fr = 8'd0;

      // boundary pin
      if (tx_block_boundary_in && !r_reg.ctrl[`ATX_B_BBOUT]) begin
         if (r_reg.bbcnt != `ATX_BB_MIN_HI)
            r_next.bbcnt = r_reg.bbcnt + 3'd1;
         r_next.bbd = r_reg.bbd | bbtrig;
      end else begin
         r_next.bbcnt = 3'd0;
         r_next.bbd   = 1'b0;
      end
      r_next.bbo = r_next.fr == 8'd0;

      // load subframe data bits
      if (cons) begin
         if (cons_a) begin
            aud = r_reg.pend ? r_reg.pl : r_reg.hl;
            if (r_reg.pend) begin
               r_next.hl = r_reg.pl;
               r_next.hr = r_reg.pr;
            end
            r_next.pend = pair_done;
         end
         r_next.dsh = mkword(aud, csf[r_reg.fr],
                             r_reg.ctrl[`ATX_B_UPIN] ? user_data_in : usf[r_reg.fr],
                             r_reg.ctrl[`ATX_B_VAL], mute);
      end

      // bi-phase mark coder, two clocks per half cell
      if (!r_reg.fcnt[0]) begin
         if (hs < 6'd8) begin
            if (r_reg.fcnt[7])
               pat = `ATX_PRE_W;
            else if (r_reg.fr == 8'd0)
               pat = `ATX_PRE_B;
            if (hs == 6'd0)
               r_next.p0 = r_reg.lvl;
            else
               base = r_reg.p0;
            r_next.lvl = pat[3'd7 - hs[2:0]] ^ base;
         end else if (!hs[0]) begin
            r_next.lvl = ~r_reg.lvl;
         end else begin
            if (r_reg.dsh[0])
               r_next.lvl = ~r_reg.lvl;
            r_next.dsh = r_reg.dsh >> 1;
         end
      end
      r_next.pos = on_c & r_next.lvl;
      r_next.neg = on_c & ~r_next.lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         r_reg <= '0;
      else
         r_reg <= r_next;
   end

   assign prdata                = r_reg.rdata;
   assign pready                = r_reg.rdy;
   assign pslverr               = r_reg.err;
   assign input_word_clock_out  = r_reg.wck;
   assign input_word_clock_oe   = r_reg.ctrl[`ATX_B_MS];
   assign input_bit_clock_out   = r_reg.bck;
   assign input_bit_clock_oe    = r_reg.ctrl[`ATX_B_MS];
   assign tx_block_boundary_out = r_reg.bbo;
   assign tx_block_boundary_oe  = r_reg.ctrl[`ATX_B_BBOUT];
   assign tx_slip_flag          = r_reg.slip;
   assign line_out_pos          = r_reg.pos;
   assign line_out_neg          = r_reg.neg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   line_compl_a: assert property ($past(on_c) |-> line_out_pos == ~line_out_neg)
      else $error("line outputs not complementary");
   drv_off_a: assert property (!$past(on_c) |-> !line_out_pos && !line_out_neg)
      else $error("line driven while off");
   slip_set_a: assert property (slipev |=> tx_slip_flag ##1 (tx_slip_flag || $past(wr && idx == `ATX_IDX_STAT && pwdata[0])))
      else $error("slip not flagged");
   mute_zero_a: assert property (cons && mute |=> r_reg.dsh[23:0] == 24'h000000)
      else $error("muted sample not silent");
   bb_restart_a: assert property (bbtrig |=> r_reg.fcnt == 8'h00 && r_reg.fr == 8'd0 ##1 r_reg.fcnt == 8'h01)
      else $error("boundary input did not restart block");
   align_a: assert property (align_ev |=> r_reg.fcnt == 8'h00)
      else $error("frame not aligned to word clock");
   master_wck_a: assert property (ms && r_reg.fcnt == 8'h80 |=> input_word_clock_out == r_reg.ctrl[`ATX_B_WPOL])
      else $error("master word clock phase wrong");
   frame_step_a: assert property (!frc && r_reg.fcnt != 8'hff |=> r_reg.fcnt == $past(r_reg.fcnt) + 8'd1)
      else $error("frame counter skipped");
   block_wrap_a: assert property (!frc && r_reg.fcnt == 8'hff && r_reg.fr == 8'd191 |=> r_reg.fr == 8'd0)
      else $error("block length not 192");
   pair_take_a: assert property (pair_done && !cons_a |=> r_reg.pend)
      else $error("sample pair lost");

   slip_c: cover property (slipev);
   bb_c: cover property (bbtrig);
   align_c: cover property (align_ev ##[1:300] pair_done);
   mute_c: cover property (cons && mute && on_c);

endmodule // atx_transmitter
`default_nettype wire

// file: atx_defines.svh
// Purpose: offsets, field positions and timing counts of the transmitter
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: memory words are addressed by word index
`ifndef ATX_DEFINES_SVH
`define ATX_DEFINES_SVH

`define ATX_IDX_CTRL     5'h00
`define ATX_IDX_STAT     5'h01
`define ATX_IDX_CS       5'h04
`define ATX_IDX_US       5'h0c
`define ATX_MEM_WORDS    6

`define ATX_B_MS         0
`define ATX_B_RATE       1
`define ATX_B_RES_LO     2
`define ATX_B_JR         4
`define ATX_B_DLY        5
`define ATX_B_BPOL       6
`define ATX_B_WPOL       7
`define ATX_B_MUTE       8
`define ATX_B_TXOFF      9
`define ATX_B_BBOUT      10
`define ATX_B_UPIN       11
`define ATX_B_RUN        12
`define ATX_B_VAL        13
`define ATX_CTRL_W       14

`define ATX_BB_MIN_HI    3'd3
`define ATX_BLOCK_LAST   8'd191
`define ATX_MAX_BITS     8'd128
`define ATX_LOAD_SLOT    7'h0f
`define ATX_PRE_B        8'he8
`define ATX_PRE_M        8'he2
`define ATX_PRE_W        8'he4

`endif

// file: atx_pkg.sv
// Purpose: types of the transmitter
// Assumes: nothing
// Notes: the whole module state is one struct
`default_nettype none
package atx_pkg;
   typedef struct packed {
      logic [31:0]      rdata;
      logic             rdy;
      logic             err;
      logic [13:0]      ctrl;
      logic             slip;
      logic [5:0][31:0] cs;
      logic [5:0][31:0] us;
      logic [7:0]       fcnt;
      logic [7:0]       fr;
      logic             bck;
      logic             wck;
      logic             bs1;
      logic             ws1;
      logic             sd1;
      logic             bpa;
      logic             wsl;
      logic             lastwc;
      logic [7:0]       n;
      logic [23:0]      sh;
      logic [23:0]      lw;
      logic [23:0]      pl;
      logic [23:0]      pr;
      logic             pend;
      logic [23:0]      hl;
      logic [23:0]      hr;
      logic [27:0]      dsh;
      logic             lvl;
      logic             p0;
      logic             pos;
      logic             neg;
      logic             bbo;
      logic [2:0]       bbcnt;
      logic             bbd;
   } atx_st_t;
endpackage : atx_pkg
`default_nettype wire

// file: atx_partner.sv
// Purpose: serial audio source and bi-phase mark line receiver
// Assumes: 256 pclk per source frame plus gap, bit clock period 4 pclk
// Notes: fmt is {word pol, bit pol, delay, right justify}; unused data slots toggle
`default_nettype none
module atx_partner (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [3:0]  fmt,
   input  wire logic [5:0]  gap,
   input  wire logic [23:0] left,
   input  wire logic [23:0] right,
   output logic             word_clock,
   output logic             bit_clock,
   output logic             sdata,
   input  wire logic        line_in,
   output logic             sf_valid,
   output logic [1:0]       sf_pre,
   output logic [27:0]      sf_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0]  cnt;
   logic [5:0]  k;
   logic [23:0] smp;
   logic        prv;
   logic        half;
   logic [3:0]  c;
   logic [3:0]  hc;
   logic [4:0]  nb;
   logic [1:0]  pre;
   logic [27:0] sh;
   logic [2:0]  rn;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) cnt <= '0;
      else cnt <= (cnt >= 9'd255 + 9'(gap)) ? '0 : cnt + 9'd1;
   // word clock stays synchronous and continuous; bit clock stands still in the gap
   assign word_clock = (cnt < 9'd128) ^ fmt[3];
   assign bit_clock  = cnt[8] ? fmt[2] : cnt[1] ^ fmt[2];
   assign k          = 6'(cnt[6:2]) - 6'(fmt[1]) - (fmt[0] ? 6'd8 : 6'd0);
   assign smp        = cnt[7] ? right : left;
   assign sdata      = (!cnt[8] && k < 6'd24) ? smp[5'd23 - k[4:0]] : cnt[0];
   // receiver: run lengths in half cells, a run of three opens a preamble
   assign rn = c[3:1];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) begin
         {prv, half, c, hc, nb, pre, sh, sf_valid, sf_pre, sf_bits} <= '0;
      end else begin
         sf_valid <= 1'b0;
         if (line_in == prv) c <= (c == 4'd15) ? c : c + 4'd1;
         else begin
            c   <= 4'd1;
            prv <= line_in;
            if (rn == 3'd3 && hc >= 4'd8) begin
               sf_valid       <= (nb == 5'd28);
               sf_pre         <= pre;
               sf_bits        <= sh;
               {hc, nb, half} <= {4'd3, 5'd0, 1'b0};
            end else begin
               if (hc < 4'd8) hc <= hc + 4'(rn);
               if (hc == 4'd3) pre <= rn[1:0];
               if (hc >= 4'd8 && rn == 3'd2) {sh, nb} <= {1'b0, sh[27:1], nb + 5'd1};
               if (hc >= 4'd8 && rn == 3'd1) begin
                  half <= ~half;
                  if (half) {sh, nb} <= {1'b1, sh[27:1], nb + 5'd1};
               end
            end
         end
      end
endmodule // atx_partner
`default_nettype wire

// file: tb_aes3_audio_transmitter.sv
// Purpose: self-checking bench of the transmitter
// Assumes: partner drives the port in slave role; seed fixed
// Notes: subframes right after a setting change are skipped
`include "atx_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
   $display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb_aes3_audio_transmitter;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] K_RUN = 32'h1 << `ATX_B_RUN;
   localparam logic [31:0] K_BBO = 32'h1 << `ATX_B_BBOUT;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, user_bit = 0, bb_drv = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic        pready, pslverr, e, wck_o, wck_oe, bck_o, bck_oe, bb_o, bb_oe, slip, pos, neg;
   logic        src_w, src_b, src_d, sfv, seen, pw, pb, comp_on = 0;
   logic [1:0]  sp, pre;
   logic [27:0] sb, bits;
   logic [3:0]  fmt = '0;
   logic [3:0]  fmts [4] = '{4'h0, 4'ha, 4'h1, 4'h4};
   logic [5:0]  gap = '0;
   logic [23:0] lft = '0, rgt = '0;
   logic [31:0] cs [6], us [6];
   int          seed = 32906, mismatches = 0, n_compared = 0, fidx = 0, nb, n, ed, st, last;
   wire         wck_w = wck_oe ? wck_o : src_w;
   wire         bck_w = bck_oe ? bck_o : src_b;
   wire         bb_w  = bb_oe ? bb_o : bb_drv;
   atx_transmitter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_word_clock_in(wck_w), .input_word_clock_out(wck_o), .input_word_clock_oe(wck_oe),
      .input_bit_clock_in(bck_w), .input_bit_clock_out(bck_o), .input_bit_clock_oe(bck_oe),
      .serial_audio_in(src_d), .user_data_in(user_bit), .tx_block_boundary_in(bb_w),
      .tx_block_boundary_out(bb_o), .tx_block_boundary_oe(bb_oe), .tx_slip_flag(slip),
      .line_out_pos(pos), .line_out_neg(neg));
   atx_partner src (.pclk(pclk), .presetn(presetn), .fmt(fmt), .gap(gap), .left(lft), .right(rgt),
      .word_clock(src_w), .bit_clock(src_b), .sdata(src_d), .line_in(pos), .sf_valid(sfv),
      .sf_pre(sp), .sf_bits(sb));
   always #2 pclk = ~pclk;
   always @(posedge pclk) if (comp_on) `CHK("line_pair", ~pos, neg)
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) mismatches++;
   endtask
   task automatic next_sf();
      n = 0;
      do begin @(posedge pclk); n++; end while (sfv !== 1'b1 && n < 400);
      pre = sp;
      bits = sb;
      if (n >= 400) mismatches++;
      if (sp == 2'd1) fidx = 0;
      else if (sp == 2'd3) fidx++;
   endtask
   function automatic logic [27:0] exp_sub(logic [23:0] s, logic v, logic u, logic c);
      return {^{c, u, v, s}, c, u, v, s};
   endfunction
   task automatic check_pair(input int skip, input logic [23:0] l, r, input logic v, u);
      repeat (skip) next_sf();
      do next_sf(); while (pre == 2'd2 && n < 400);
      `CHK("sub_a", exp_sub(l, v, u, 1'b0), bits)
      next_sf();
      `CHK("sub_b", {2'd2, exp_sub(r, v, u, 1'b0)}, {pre, bits})
   endtask
   task automatic pulse(input int w);
      @(posedge pclk);
      bb_drv <= 1'b1;
      repeat (w) @(posedge pclk);
      bb_drv <= 1'b0;
      seen = 0;
      repeat (6) begin next_sf(); seen |= (pre === 2'd1); end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin #360000; mismatches++; print_verdict(); end
   initial begin
      for (int i = 0; i < 6; i++) begin cs[i] = $random(seed); us[i] = $random(seed); end
      repeat (5) begin @(posedge pclk); `CHK("line_reset", 2'b00, {pos, neg}) end
      presetn <= 1'b1;
      apb(0, 12'h000, 0);
      `CHK("ctrl_reset", 32'h0, q)
      apb(0, 12'h0fc, 0);
      `CHK("unmapped", {1'b1, 32'h0}, {e, q})
      repeat (100) begin @(posedge pclk); `CHK("line_stopped", 2'b00, {pos, neg}) end
      $display("test reset done");
      foreach (fmts[f]) begin
         @(posedge pclk);
         fmt <= fmts[f];
         lft <= 24'($random(seed));
         rgt <= 24'($random(seed));
         apb(1, 12'h000, K_RUN | K_BBO | (32'(fmts[f]) << `ATX_B_JR));
         check_pair(6, lft, rgt, 1'b0, 1'b0);
         comp_on <= 1'b1;
      end
      $display("test formats done");
      @(posedge pclk);
      fmt <= 4'h0;
      apb(1, 12'h000, K_RUN | K_BBO | (32'h1 << `ATX_B_MUTE));
      check_pair(2, 24'h0, 24'h0, 1'b0, 1'b0);
      `CHK("bb_dir", 1'b1, bb_oe)
      for (int u = 1; u >= 0; u--) begin
         @(posedge pclk);
         user_bit <= u[0];
         apb(1, 12'h000, K_RUN | K_BBO | (32'h1 << `ATX_B_UPIN));
         check_pair(4, lft, rgt, 1'b0, u[0]);
      end
      $display("test mute and user pin done");
      apb(1, 12'h000, K_RUN);
      repeat (4) next_sf();
      apb(1, 12'h004, 32'h1);
      repeat (8) next_sf();
      apb(0, 12'h004, 0);
      `CHK("slip_quiet", 1'b0, q[0])
      @(posedge pclk);
      gap <= 6'd32;
      check_pair(24, lft, rgt, 1'b0, 1'b0);
      `CHK("slip_flag", 1'b1, slip)
      apb(0, 12'h004, 0);
      `CHK("slip_status", 1'b1, q[0])
      @(posedge pclk);
      gap <= 6'd0;
      $display("test slip done");
      for (int i = 0; i < 6; i++) begin
         apb(1, 12'h010 + 12'(i * 4), cs[i]);
         apb(1, 12'h030 + 12'(i * 4), us[i]);
      end
      apb(1, 12'h000, K_RUN | (32'h1 << `ATX_B_VAL));
      pulse(4);
      `CHK("block_start", 1'b1, seen)
      pulse(3);
      `CHK("short_pulse", 1'b0, seen)
      nb = 0;
      do begin
         last = fidx;
         next_sf();
         `CHK("sub_cuv", exp_sub((pre == 2'd2) ? rgt : lft, 1'b1, us[fidx/32][fidx%32], cs[fidx/32][fidx%32]), bits)
         `CHK("bb_out", (pre == 2'd1) || (pre == 2'd2 && fidx == 191), bb_o)
         nb++;
      end while (pre !== 2'd1 && nb < 400);
      `CHK("block_len", 191, last)
      $display("test block done");
      for (int r = 0; r < 2; r++) begin
         apb(1, 12'h000, K_RUN | 32'h1 | (32'(r) << `ATX_B_RATE));
         repeat (2) next_sf();
         {n, ed, st, pw, pb} = {32'd0, 32'd0, 32'd0, wck_o, bck_o};
         repeat (600) begin
            @(posedge pclk);
            if (wck_o && !pw) st++;
            if (st == 1) begin n++; ed += int'(bck_o && !pb); end
            pw = wck_o;
            pb = bck_o;
         end
         `CHK("clock_oe", 2'b11, {wck_oe, bck_oe})
         `CHK("frame_len", 256, n)
         `CHK("bit_clocks", r ? 128 : 64, ed)
      end
      $display("test master done");
      @(posedge pclk);
      comp_on <= 1'b0;
      for (int m = 0; m < 2; m++) begin
         apb(1, 12'h000, m ? 32'h0 : K_RUN | (32'h1 << `ATX_B_TXOFF));
         repeat (3) @(posedge pclk);
         repeat (300) begin @(posedge pclk); `CHK("line_off", 2'b00, {pos, neg}) end
      end
      $display("test driver off done");
      print_verdict();
   end
endmodule // tb_aes3_audio_transmitter
`default_nettype wire
